// File: design/mhp_regs.svh
// Purpose: register offsets, field positions, command bytes and reset values of the host port
// Assumes: byte-wide odd-address register window of sixteen bytes
// Notes:   definitions only
`ifndef MHP_REGS_SVH
`define MHP_REGS_SVH

// register offsets inside the sixteen-byte window
`define MHP_OFF_DATA     4'h1
`define MHP_OFF_DONE     4'h3
`define MHP_OFF_ENABLE   4'h5
`define MHP_OFF_STATUS   4'h7
`define MHP_OFF_VECTOR   4'h9
`define MHP_OFF_UNUSED0  4'hb

// interrupt enable bit positions
`define MHP_EN_MASTER    7
`define MHP_EN_TX        6
`define MHP_EN_RX        5
`define MHP_EN_DONE      4
`define MHP_ENABLE_MASK  8'hf0

// number of axes with a completion flag
`define MHP_AXES         4

// command bytes seen on the data port
`define MHP_CMD_CLR_ERR  8'h18
`define MHP_CMD_CLR_ALL  8'h19
`define MHP_CMD_IC_FIRST 8'h49
`define MHP_CMD_IC_LAST  8'h43

// reset values
`define MHP_RST_ENABLE   8'h00
`define MHP_RST_VECTOR   8'h0f
`define MHP_RST_BYTE     8'h00
`define MHP_RST_DONE     4'h0
`define MHP_READ_ZERO    8'h00

`endif

// File: design/mhp_pkg.sv
// Purpose: shared types of the motion host port
// Assumes: nothing beyond the register header
// Notes:   status struct order is the status register bit order, msb first
package mhp_pkg;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK,
      BUS_PASS
   } mhp_bus_state_t;

   // backplane inputs after the two-flop synchroniser
   typedef struct packed {
      logic [15:1] addr;
      logic [7:0]  data;
      logic [11:0] base;
      logic [2:0]  level;
      logic        asN;
      logic        ds0N;
      logic        ds1N;
      logic        writeN;
      logic        lwordN;
      logic        iackInN;
   } mhp_pins_t;

   typedef struct packed {
      logic irqReq;
      logic txSpace;
      logic rxAvail;
      logic complete;
      logic travel;
      logic encoder;
      logic init;
      logic cmdErr;
   } mhp_status_t;

endpackage

// File: design/mhp_byte_buf.sv
// Purpose: two-deep byte buffer, one per direction of the data port
// Assumes: push and pop come from logic on the same clock
// Notes:   a push into a full buffer is dropped unless the head leaves in the same cycle; head and flags are registered
`timescale 1ns/1ps
`default_nettype none
`include "mhp_regs.svh"
module mhp_byte_buf (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // filling side
   input  wire logic       pushValid,
   input  wire logic [7:0] pushData,
   output logic            spaceFlag,
   // draining side
   input  wire logic       popReady,
   output logic [7:0]      headData,
   output logic            headValid
);
   logic [7:0] tail_ff;
   logic       tailValid_ff;
   logic       doPop;
   logic       doPush;
   logic [7:0] nxt_head;
   logic [7:0] nxt_tail;
   logic       nxt_headValid;
   logic       nxt_tailValid;

   assign doPop  = popReady && headValid;
   // a full buffer still takes a byte when the head leaves in the same cycle
   assign doPush = pushValid && (!tailValid_ff || doPop);

   always_comb begin
      nxt_head      = headData;
      nxt_tail      = tail_ff;
      nxt_headValid = headValid;
      nxt_tailValid = tailValid_ff;
      if (doPop) begin
         nxt_head      = tail_ff;
         nxt_headValid = tailValid_ff;
         nxt_tailValid = 1'b0;
      end
      if (doPush) begin
         if (!nxt_headValid) begin
            nxt_head      = pushData;
            nxt_headValid = 1'b1;
         end else begin
            nxt_tail      = pushData;
            nxt_tailValid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         headData     <= `MHP_RST_BYTE;
         tail_ff      <= `MHP_RST_BYTE;
         headValid    <= 1'b0;
         tailValid_ff <= 1'b0;
         spaceFlag    <= 1'b1;
      end else begin
         headData     <= nxt_head;
         tail_ff      <= nxt_tail;
         headValid    <= nxt_headValid;
         tailValid_ff <= nxt_tailValid;
         spaceFlag    <= !nxt_tailValid;
      end
   end
endmodule
`default_nettype wire

// File: design/mhp_host_port.sv
// Purpose: backplane host port of a four-axis motion controller
// Assumes: ref_clk 250 MHz; backplane pins asynchronous; firmware side on ref_clk
// Notes:   open-drain lines are out/oe pairs, oe high while driving low
// Function
// - decode sixteen addresses, answer only odd ones, ignore even accesses
// - data 1, done flags 3, enables 5, status 7, vector 9; 11-15 unused
// - data port buffered two deep each direction
// - completion flags bits 0-3 order X Y Z T, bits 4-7 zero
// - completion flags read-only, set by firmware, cleared by host read
// - four enables written any time: master 7, tx 6, rx 5, done 4
// - enable register reads back, bits 3-0 read zero
// - status flags update regardless of enables, polling works
// - status bit 7 is OR of bits 4, 5 and 6
// - bit 6 set while tx buffer has room, cleared by write when full
// - bit 5 set while rx byte waits, cleared by read unless another waits
// - bit 4 set on completion or error, cleared by status read
// - bit 3 set when an overtravel switch trips
// - bit 2 set when encoder option requests service
// - bit 1 high only while board initialises, then low
// - command error flag on bad command or unmatched loop commands
// - byte 0x18 clears error bits, completion flags untouched
// - interrupt-clear command or Control-Y clears completion flags and errors
// - vector register read/write, returned on winning interrupt acknowledge
// - interrupt on one jumper level 1 to 7 from the status sources
// - only single byte transfers at odd addresses
`timescale 1ns/1ps
`default_nettype none
`include "mhp_regs.svh"
module mhp_host_port (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // backplane address and strobes
   input  wire logic [15:1] vmeAddr,
   input  wire logic        vmeAsN,
   input  wire logic        vmeDs0N,
   input  wire logic        vmeDs1N,
   input  wire logic        vmeWriteN,
   input  wire logic        vmeLwordN,
   input  wire logic        vmeIackInN,
   // backplane data byte
   input  wire logic [7:0]  vmeDataIn,
   output logic [7:0]       vmeDataOut,
   output logic             vmeDataOe,
   // backplane acknowledge, daisy chain and interrupt lines
   output logic             vmeDtackOut,
   output logic             vmeDtackOe,
   output logic             vmeIackOutN,
   output logic [6:0]       vmeIrqOut,
   output logic [6:0]       vmeIrqOe,
   // jumpers
   input  wire logic [11:0] boardBase,
   input  wire logic [2:0]  irqLevel,
   // firmware command stream
   output logic [7:0]       cmdData,
   output logic             cmdValid,
   input  wire logic        cmdTake,
   // firmware response stream
   input  wire logic [7:0]  respData,
   input  wire logic        respValid,
   output logic             respReady,
   // firmware events
   input  wire logic [3:0]  axisDoneSet,
   input  wire logic        completionSet,
   input  wire logic        cmdErrorSet,
   input  wire logic        travelLimitSet,
   input  wire logic        encoderServiceSet,
   input  wire logic        initBusy
);
   localparam int PW = $bits(mhp_pkg::mhp_pins_t);

   logic [PW-1:0]                pinMeta_ff;
   logic [PW-1:0]                pinSync_ff;
   mhp_pkg::mhp_pins_t           pins;
   mhp_pkg::mhp_bus_state_t      st_ff;
   mhp_pkg::mhp_status_t         status;
   logic [3:0]                   regOff;
   logic                         hit;
   logic                         oddCycle;
   logic                         regAccess;
   logic                         hostRead;
   logic                         hostWrite;
   logic                         iackCycle;
   logic                         iackOurs;
   logic                         iackOther;
   logic                         rdData;
   logic                         rdDone;
   logic                         rdStatus;
   logic                         wrData;
   logic                         wrEnable;
   logic                         wrVector;
   logic                         ctrlX;
   logic                         ctrlY;
   logic                         icCmd;
   logic                         txPush;
   logic                         txSpace;
   logic                         rxAvail;
   logic [7:0]                   rxHead;
   logic                         errClr;
   logic                         anyError;
   logic [7:0]                   rdMux;
   logic [6:0]                   nxt_irqOe;
   logic [7:0]                   lastByte_ff;
   logic [`MHP_AXES-1:0]         doneFlags_ff;
   logic                         travel_ff;
   logic                         encoder_ff;
   logic                         cmdErr_ff;
   logic                         complete_ff;
   logic                         init_ff;
   logic [7:0]                   enable_ff;
   logic [7:0]                   vector_ff;
   logic                         irqReq_ff;

   // every backplane and jumper input crosses through two flops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinMeta_ff <= '1;
         pinSync_ff <= '1;
      end else begin
         pinMeta_ff <= {vmeAddr, vmeDataIn, boardBase, irqLevel, vmeAsN, vmeDs0N,
                        vmeDs1N, vmeWriteN, vmeLwordN, vmeIackInN};
         pinSync_ff <= pinMeta_ff;
      end
   end
   assign pins = mhp_pkg::mhp_pins_t'(pinSync_ff);

   // decode: odd byte lane only, long-word and even-lane cycles get no answer
   assign oddCycle  = !pins.asN && !pins.ds0N && pins.ds1N && pins.lwordN;
   assign hit       = pins.addr[15:4] == pins.base;
   assign regOff    = {pins.addr[3:1], 1'b1};
   assign regAccess = (st_ff == mhp_pkg::BUS_IDLE) && oddCycle && pins.iackInN && hit;
   assign hostRead  = regAccess && pins.writeN;
   assign hostWrite = regAccess && !pins.writeN;
   assign iackCycle = (st_ff == mhp_pkg::BUS_IDLE) && !pins.asN && !pins.ds0N && !pins.iackInN;
   assign iackOurs  = iackCycle && irqReq_ff && (pins.addr[3:1] == pins.level);
   assign iackOther = iackCycle && !iackOurs;

   // per-register strobes, each once per bus cycle
   assign rdData   = hostRead && (regOff == `MHP_OFF_DATA);
   assign rdDone   = hostRead && (regOff == `MHP_OFF_DONE);
   assign rdStatus = hostRead && (regOff == `MHP_OFF_STATUS);
   assign wrData   = hostWrite && (regOff == `MHP_OFF_DATA);
   assign wrEnable = hostWrite && (regOff == `MHP_OFF_ENABLE);
   assign wrVector = hostWrite && (regOff == `MHP_OFF_VECTOR);

   // control bytes act at once; the two-letter clear also goes on to firmware
   assign ctrlX  = wrData && (pins.data == `MHP_CMD_CLR_ERR);
   assign ctrlY  = wrData && (pins.data == `MHP_CMD_CLR_ALL);
   assign icCmd  = wrData && (lastByte_ff == `MHP_CMD_IC_FIRST)
                   && (pins.data == `MHP_CMD_IC_LAST);
   assign txPush = wrData && !ctrlX && !ctrlY;
   assign errClr = ctrlX || ctrlY || icCmd;
   assign anyError = cmdErrorSet || travelLimitSet || encoderServiceSet;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lastByte_ff <= `MHP_RST_BYTE;
      end else if (wrData) begin
         lastByte_ff <= pins.data;
      end
   end

   mhp_byte_buf uTxBuf (
      .clk       (ref_clk),
      .rst       (rst),
      .pushValid (txPush),
      .pushData  (pins.data),
      .spaceFlag (txSpace),
      .popReady  (cmdTake),
      .headData  (cmdData),
      .headValid (cmdValid)
   );

   mhp_byte_buf uRxBuf (
      .clk       (ref_clk),
      .rst       (rst),
      .pushValid (respValid),
      .pushData  (respData),
      .spaceFlag (respReady),
      .popReady  (rdData),
      .headData  (rxHead),
      .headValid (rxAvail)
   );

   // completion flags: firmware sets, a set in the clearing cycle survives
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         doneFlags_ff <= `MHP_RST_DONE;
      end else begin
         doneFlags_ff <= (doneFlags_ff & ~{`MHP_AXES{rdDone || ctrlY || icCmd}})
                         | axisDoneSet;
      end
   end

   // error bits
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         travel_ff  <= 1'b0;
         encoder_ff <= 1'b0;
         cmdErr_ff  <= 1'b0;
      end else begin
         travel_ff  <= (travel_ff && !errClr) || travelLimitSet;
         encoder_ff <= (encoder_ff && !errClr) || encoderServiceSet;
         cmdErr_ff  <= (cmdErr_ff && !errClr) || cmdErrorSet;
      end
   end

   // done-or-error flag, cleared by reading status
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         complete_ff <= 1'b0;
      end else begin
         complete_ff <= (complete_ff && !rdStatus) || completionSet || anyError;
      end
   end

   // busy flag stays high through reset until the firmware reports ready
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_ff <= 1'b1;
      end else begin
         init_ff <= initBusy;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enable_ff <= `MHP_RST_ENABLE;
      end else if (wrEnable) begin
         enable_ff <= pins.data & `MHP_ENABLE_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vector_ff <= `MHP_RST_VECTOR;
      end else if (wrVector) begin
         vector_ff <= pins.data;
      end
   end

   // status view is built from raw flags, never gated by the enables
   always_comb begin
      status.txSpace  = txSpace;
      status.rxAvail  = rxAvail;
      status.complete = complete_ff;
      status.travel   = travel_ff;
      status.encoder  = encoder_ff;
      status.init     = init_ff;
      status.cmdErr   = cmdErr_ff;
      status.irqReq   = txSpace || rxAvail || complete_ff;
   end

   // interrupt request and the one jumper-chosen line it drives
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqReq_ff <= 1'b0;
      end else begin
         irqReq_ff <= enable_ff[`MHP_EN_MASTER]
                      && ((enable_ff[`MHP_EN_TX] && txSpace)
                       || (enable_ff[`MHP_EN_RX] && rxAvail)
                       || (enable_ff[`MHP_EN_DONE] && complete_ff));
      end
   end

   always_comb begin
      for (int i = 0; i < 7; i++) begin
         nxt_irqOe[i] = irqReq_ff && (pins.level == 3'(i + 1));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vmeIrqOe <= '0;
      end else begin
         vmeIrqOe <= nxt_irqOe;
      end
   end

   // open-drain lines only ever pull low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vmeDtackOut <= 1'b0;
         vmeIrqOut   <= '0;
      end else begin
         vmeDtackOut <= 1'b0;
         vmeIrqOut   <= '0;
      end
   end

   always_comb begin
      case (regOff)
         `MHP_OFF_DATA:   rdMux = rxHead;
         `MHP_OFF_DONE:   rdMux = {4'h0, doneFlags_ff};
         `MHP_OFF_ENABLE: rdMux = enable_ff;
         `MHP_OFF_STATUS: rdMux = status;
         `MHP_OFF_VECTOR: rdMux = vector_ff;
         default:         rdMux = `MHP_READ_ZERO;
      endcase
   end

   // bus cycle: answer once, hold data and acknowledge until the strobe leaves
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff       <= mhp_pkg::BUS_IDLE;
         vmeDataOut  <= `MHP_READ_ZERO;
         vmeDataOe   <= 1'b0;
         vmeDtackOe  <= 1'b0;
         vmeIackOutN <= 1'b1;
      end else begin
         case (st_ff)
            mhp_pkg::BUS_IDLE: begin
               if (regAccess) begin
                  st_ff      <= mhp_pkg::BUS_ACK;
                  vmeDataOut <= rdMux;
                  vmeDataOe  <= pins.writeN;
                  vmeDtackOe <= 1'b1;
               end else if (iackOurs) begin
                  st_ff      <= mhp_pkg::BUS_ACK;
                  vmeDataOut <= vector_ff;
                  vmeDataOe  <= 1'b1;
                  vmeDtackOe <= 1'b1;
               end else if (iackOther) begin
                  st_ff       <= mhp_pkg::BUS_PASS;
                  vmeIackOutN <= 1'b0;
               end
            end
            mhp_pkg::BUS_ACK: begin
               if (pins.ds0N || pins.asN) begin
                  st_ff      <= mhp_pkg::BUS_IDLE;
                  vmeDataOe  <= 1'b0;
                  vmeDtackOe <= 1'b0;
               end
            end
            mhp_pkg::BUS_PASS: begin
               if (pins.asN) begin
                  st_ff       <= mhp_pkg::BUS_IDLE;
                  vmeIackOutN <= 1'b1;
               end
            end
            default: begin
               st_ff <= mhp_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_regRead(logic [3:0] off);
      regAccess && pins.writeN && (regOff == off);
   endsequence

   sequence s_regWrite(logic [3:0] off);
      regAccess && !pins.writeN && (regOff == off);
   endsequence

   a_even_no_ack: assert property (
      (st_ff == mhp_pkg::BUS_IDLE) && !pins.asN && pins.ds0N && !pins.ds1N |=> !vmeDtackOe)
      else $error("even byte access was acknowledged");

   a_unused_zero: assert property (
      s_regRead(`MHP_OFF_UNUSED0) |=> vmeDtackOe && vmeDataOe && (vmeDataOut == 8'h00))
      else $error("unused offset did not read zero");

   a_tx_second_byte: assert property (
      txPush && cmdValid && !cmdTake && txSpace |=> cmdValid && !txSpace)
      else $error("second buffered byte not held");

   a_done_read_value: assert property (
      s_regRead(`MHP_OFF_DONE) |=> vmeDataOut == {4'h0, $past(doneFlags_ff)})
      else $error("completion flags read wrong value");

   a_done_rd_clear: assert property (
      s_regRead(`MHP_OFF_DONE) ##0 (axisDoneSet == 4'h0) |=> doneFlags_ff == 4'h0)
      else $error("completion flags not cleared by read");

   a_enable_rdback: assert property (
      s_regRead(`MHP_OFF_ENABLE) |=> (vmeDataOut[3:0] == 4'h0)
         && (vmeDataOut[7:4] == $past(enable_ff[7:4])))
      else $error("enable readback wrong");

   a_status_or: assert property (
      s_regRead(`MHP_OFF_STATUS) |=> vmeDataOut[7] == (|vmeDataOut[6:4]))
      else $error("status bit 7 is not the or of bits 4 to 6");

   a_status_rd_clear: assert property (
      s_regRead(`MHP_OFF_STATUS) ##0 !completionSet && !anyError |=> !complete_ff)
      else $error("done-or-error flag not cleared by status read");

   a_ctrlx_keeps_done: assert property (
      s_regWrite(`MHP_OFF_DATA) ##0 (pins.data == `MHP_CMD_CLR_ERR) && !anyError
         && (axisDoneSet == 4'h0)
      |=> (doneFlags_ff == $past(doneFlags_ff)) && !travel_ff && !encoder_ff && !cmdErr_ff)
      else $error("clear-error byte misbehaved");

   a_master_off: assert property (
      !enable_ff[`MHP_EN_MASTER] [*2] |=> vmeIrqOe == 7'h00)
      else $error("interrupt line held without master enable");

   a_irq_needs_enable: assert property (
      vmeIrqOe != 7'h00 |-> $past(enable_ff[`MHP_EN_MASTER], 2))
      else $error("interrupt raised without master enable");

   a_vector_ack: assert property (
      iackOurs |=> vmeDataOe && vmeDtackOe && (vmeDataOut == vector_ff))
      else $error("vector not returned on acknowledge");

   a_iack_pass: assert property (
      iackOther |=> !vmeIackOutN && !vmeDtackOe)
      else $error("foreign acknowledge not passed on");

endmodule
`default_nettype wire

// File: sim/mhp_bus_host.sv
// Purpose: backplane master that issues single byte cycles to the port
// Assumes: cycles are launched and released at the falling edge
// Notes:   released data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module mhp_bus_host #(
   parameter logic [11:0] BASE = 12'hff8,
   parameter logic [2:0]  LVL  = 3'h3
) (
   // clock
   input  wire logic       clk,
   // answer lines
   input  wire logic       dtackOe,
   input  wire logic       dataOe,
   input  wire logic       iackOutN,
   input  wire logic [7:0] dataOut,
   // cycle lines
   output var mhp_pkg::mhp_pins_t p
);
   logic [7:0] rd;
   logic       ok;
   logic       oe;

   // byte transfers only, strobes idle high
   initial p = {15'h0, 8'h00, BASE, LVL, 6'h3f};

   task automatic cyc(logic wr, logic ak, logic odd, logic [3:0] off, logic [7:0] wd);
      @(negedge clk);
      p.addr = {BASE, off[3:1]};
      p.writeN = !wr;
      p.data = wr ? wd : ~p.data;
      p.iackInN = !ak;
      p.asN = 1'b0;
      p.ds0N = !odd;
      p.ds1N = odd;
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++) begin
         @(negedge clk);
         // a passed-on acknowledge also ends the wait
         ok = dtackOe || !iackOutN;
         oe = dataOe;
         rd = dataOut;
      end
      p.asN = 1'b1;
      p.ds0N = 1'b1;
      p.ds1N = 1'b1;
      p.data = ~p.data;
      // next cycle only once the port has seen the strobes go away
      for (int n = 0; n < 16 && (dtackOe || !iackOutN); n++) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// File: sim/mhp_host_port_test.sv
// Purpose: self-checking bench of the motion host port against a byte model
// Assumes: base and level jumpers are set by the bus master model
// Notes:   irq lines are compared after every register read, register write and fired event
`timescale 1ns/1ps
`default_nettype none
module mhp_host_port_test;
   localparam logic [2:0] LVL = 3'h3;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   mhp_pkg::mhp_pins_t p;
   logic [7:0]         dOut, cmdData, respData, mEn, mVec, mDone, mSt, prevB;
   logic               dtOe, iackOutN, cmdValid, cmdTake, respValid, respReady, initBusy;
   logic               dOe, dtOut;
   logic [6:0]         irqOe, irqOut;
   logic [3:0]         axisSet, evSet;
   logic [7:0]         txq[$], rxq[$];
   int                 num_errors = 0;
   int                 n_checks = 0;
   int                 seed = 32'h669f4c23;

   always #2 clk = ~clk;

   mhp_host_port u_mhp_host_port (
      .ref_clk(clk), .rst(rst), .vmeAddr(p.addr), .vmeAsN(p.asN), .vmeDs0N(p.ds0N),
      .vmeDs1N(p.ds1N), .vmeWriteN(p.writeN), .vmeLwordN(p.lwordN), .vmeIackInN(p.iackInN),
      .vmeDataIn(p.data), .vmeDataOut(dOut), .vmeDataOe(dOe), .vmeDtackOut(dtOut),
      .vmeDtackOe(dtOe), .vmeIackOutN(iackOutN), .vmeIrqOut(irqOut), .vmeIrqOe(irqOe),
      .boardBase(p.base),
      .irqLevel(p.level), .cmdData(cmdData), .cmdValid(cmdValid), .cmdTake(cmdTake),
      .respData(respData), .respValid(respValid), .respReady(respReady),
      .axisDoneSet(axisSet), .completionSet(evSet[0]), .cmdErrorSet(evSet[1]),
      .travelLimitSet(evSet[2]), .encoderServiceSet(evSet[3]), .initBusy(initBusy));

   mhp_bus_host #(.BASE(12'hff8), .LVL(LVL)) u_mhp_bus_host (
      .clk(clk), .dtackOe(dtOe), .dataOe(dOe), .iackOutN(iackOutN), .dataOut(dOut), .p(p));

   task automatic chk(string w, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask

   function automatic logic [7:0] mStat();
      logic [7:0] s;
      s = mSt & 8'h1f;
      s[6] = txq.size() < 2;
      s[5] = rxq.size() > 0;
      s[7] = |s[6:4];
      return s;
   endfunction

   task automatic chkIrq();
      logic [7:0] s;
      logic [7:0] e;
      s = mStat();
      e = (mEn[7] && |(mEn[6:4] & s[6:4])) ? 8'h01 << (LVL - 3'h1) : 8'h00;
      chk("irq", e, {1'b0, irqOe});
      chk("od low", 8'h00, {dtOut, irqOut});
   endtask

   task automatic rdReg(logic [3:0] off);
      logic [7:0] e;
      case (off)
         4'h1: e = rxq.pop_front();
         4'h3: e = mDone;
         4'h5: e = mEn;
         4'h7: e = mStat();
         4'h9: e = mVec;
         default: e = 8'h00;
      endcase
      u_mhp_bus_host.cyc(1'b0, 1'b0, 1'b1, off, 8'h00);
      chk("ack", 8'h01, {7'h0, u_mhp_bus_host.ok});
      chk("read", e, u_mhp_bus_host.rd);
      chk("dataOe", 8'h01, {7'h0, u_mhp_bus_host.oe});
      if (off == 4'h3) mDone = 8'h00;
      if (off == 4'h7) mSt &= 8'hef;
      chkIrq();
   endtask

   task automatic wrReg(logic [3:0] off, logic [7:0] v);
      if (off == 4'h5) mEn = v & 8'hf0;
      if (off == 4'h9) mVec = v;
      if (off == 4'h1 && v == 8'h18) mSt &= 8'h12;
      if (off == 4'h1 && (v == 8'h19 || (prevB == 8'h49 && v == 8'h43))) begin
         mSt &= 8'h12;
         mDone = 8'h00;
      end
      if (off == 4'h1 && v != 8'h18 && v != 8'h19 && txq.size() < 2) txq.push_back(v);
      if (off == 4'h1) prevB = v;
      u_mhp_bus_host.cyc(1'b1, 1'b0, 1'b1, off, v);
      chk("ack", 8'h01, {7'h0, u_mhp_bus_host.ok});
      chk("dataOe", 8'h00, {7'h0, u_mhp_bus_host.oe});
      chkIrq();
   endtask

   task automatic fire(logic [3:0] ax, logic [3:0] ev);
      @(negedge clk);
      axisSet = ax;
      evSet = ev;
      @(negedge clk);
      axisSet = 4'h0;
      evSet = 4'h0;
      repeat (4) @(negedge clk);
      mDone |= {4'h0, ax};
      if (ev[0]) mSt |= 8'h10;
      if (ev[1]) mSt |= 8'h11;
      if (ev[2]) mSt |= 8'h18;
      if (ev[3]) mSt |= 8'h14;
      chkIrq();
   endtask

   task automatic push(logic [7:0] b);
      @(negedge clk);
      chk("respReady", 8'h01, {7'h0, respReady});
      respValid = 1'b1;
      respData = b;
      @(negedge clk);
      respValid = 1'b0;
      respData = ~b;
      rxq.push_back(b);
      repeat (3) @(negedge clk);
   endtask

   task automatic drain();
      while (txq.size() > 0) begin
         @(negedge clk);
         chk("cmdValid", 8'h01, {7'h0, cmdValid});
         chk("cmdData", txq.pop_front(), cmdData);
         cmdTake = 1'b1;
         @(negedge clk);
         cmdTake = 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      #80000;
      num_errors++;
      conclude();
   end

   initial begin
      {cmdTake, respValid, respData, axisSet, evSet, initBusy} = {18'h0, 1'b1};
      {mEn, mVec, mDone, mSt, prevB} = {8'h00, 8'h0f, 8'h00, 8'h02, 8'h00};
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rdReg(4'h7);
      initBusy = 1'b0;
      mSt = 8'h00;
      for (int i = 3; i < 16; i += 2) rdReg(4'(i));
      u_mhp_bus_host.cyc(1'b1, 1'b0, 1'b0, 4'h5, 8'hf0);
      chk("even ack", 8'h00, {7'h0, u_mhp_bus_host.ok});
      // long-word cycles must get no answer either
      u_mhp_bus_host.p.lwordN = 1'b0;
      u_mhp_bus_host.cyc(1'b0, 1'b0, 1'b1, 4'h7, 8'h00);
      u_mhp_bus_host.p.lwordN = 1'b1;
      chk("lword ack", 8'h00, {7'h0, u_mhp_bus_host.ok});
      for (int i = 0; i < 4; i++) begin
         wrReg(4'h5, 8'($random(seed)));
         rdReg(4'h5);
      end
      wrReg(4'h9, 8'($random(seed)));
      rdReg(4'h9);
      wrReg(4'hb, 8'h5a);
      rdReg(4'hb);
      wrReg(4'h5, 8'h90);
      rdReg(4'h5);
      // bytes kept above 0x7f so no command byte is sent by chance
      for (int i = 0; i < 3; i++) wrReg(4'h1, 8'($random(seed)) | 8'h80);
      rdReg(4'h7);
      drain();
      push(8'($random(seed)));
      push(8'($random(seed)));
      for (int i = 0; i < 2; i++) begin
         rdReg(4'h7);
         rdReg(4'h1);
      end
      fire(4'h5, 4'h1);
      u_mhp_bus_host.cyc(1'b0, 1'b1, 1'b1, {LVL, 1'b1}, 8'h00);
      chk("vector", mVec, u_mhp_bus_host.rd);
      // acknowledge for another level is passed down the chain, not answered
      u_mhp_bus_host.cyc(1'b0, 1'b1, 1'b1, 4'hb, 8'h00);
      chk("iack pass", 8'h01, {7'h0, u_mhp_bus_host.ok && !u_mhp_bus_host.oe});
      rdReg(4'h7);
      rdReg(4'h7);
      rdReg(4'h3);
      rdReg(4'h3);
      fire(4'ha, 4'he);
      rdReg(4'h7);
      wrReg(4'h1, 8'h18);
      rdReg(4'h7);
      rdReg(4'h3);
      fire(4'h3, 4'h2);
      rdReg(4'h7);
      wrReg(4'h1, 8'h19);
      rdReg(4'h7);
      rdReg(4'h3);
      fire(4'hc, 4'h4);
      rdReg(4'h7);
      wrReg(4'h1, 8'h49);
      wrReg(4'h1, 8'h43);
      rdReg(4'h7);
      rdReg(4'h3);
      drain();
      wrReg(4'h5, 8'h40);
      conclude();
   end
endmodule
`default_nettype wire
